// ### verilog/spd_consts.svh
/*
 * Offsets, field codes, reset values and fixed constants of the 16-bit datapath.
 * Assumes inclusion by bare name from the package and the datapath module.
 */
// Functional notes
// [RULE1] Sixteen scratch words, one port, never read and written together.
// [RULE2] First operand is always the wired-OR register read bus.
// [RULE3] Second operand picks a constant or one latch function.
// [RULE4] Result route picks bus data, read bus, result register or shifted result.
// [RULE5] Operand latch loads the routed value when commanded.
// [RULE6] Register pairs: first goes route to latch, second read to operand one.
// [RULE7] Constants give increments, switch address, trap vector, mask, conditional values.
// [RULE8] Direct mode passes latch high and low bytes unchanged.
// [RULE9] Sign extend copies latch bit 7 over the high byte.
// [RULE10] Duplication repeats the high or the low latch byte in both halves.
// [RULE11] Swap exchanges latch high and low bytes.
// [RULE12] ALU does 16 logic and 16 arithmetic functions, mode, select, carry-in.
// [RULE13] ALU result loads the result register, address register or both.
// [RULE14] Carry-in combines microword bit with an enabled condition input.
// [RULE15] Carry-out picks word carry, byte carry, ALU bit 15 or status carry.
// [RULE16] Selected carry-out is stored as the result register extension bit.
// [RULE17] Zero flags for the whole result word and for each byte.
// [RULE18] Address register decode gives status and switch address hits.
// [RULE19] Address below a stack limit flags yellow or red stack zone.
// [RULE20] Status word loads from route; condition codes update N Z V C alone.
// [RULE21] Status word drives system bus when addressed, else the read bus; here it drives the read bus only while status_read is set.
// [RULE22] Eight program registers plus eight internal scratch words.
// [RULE23] Route output is an outgoing bus; read bus accepts wired-OR inputs.
// [RULE24] Register enables come from the microword, applied at the state step.
// [RULE25] Status load code chooses route load over condition-code update.
// [RULE26] Unselected read bus sources drive zeros.
// [RULE27] Registers change only on a step with their enable, else hold.
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SPD_OFF_UWORD  6'h00
`define SPD_OFF_STEP   6'h04
`define SPD_OFF_RESULT 6'h08
`define SPD_OFF_ADDR   6'h0c
`define SPD_OFF_LATCH  6'h10
`define SPD_OFF_STATUS 6'h14
`define SPD_OFF_ROUTE  6'h18
`define SPD_OFF_YLIM   6'h1c
`define SPD_OFF_RLIM   6'h20

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define SPD_UW_W      28
`define SPD_ZERO16    16'h0000
`define SPD_ONES16    16'hffff
`define SPD_ZERO8     8'h00
`define SPD_YLIM_RST  16'h0100
`define SPD_RLIM_RST  16'h00e0

// ----------------------------------------
// Field positions and fixed values
// ----------------------------------------
`define SPD_SIGN_BIT  7
`define SPD_MSB       15
`define SPD_PS_N      3
`define SPD_PS_C      0
`define SPD_INC_ONE   16'h0001
`define SPD_INC_TWO   16'h0002
`define SPD_STEP_BIT  0

`endif

// ### verilog/spd_pkg.sv
/*
 * Types shared by the datapath: microword layout, selector codes, decode flags.
 * Assumes spd_consts.svh is on the include path.
 */
package spd_pkg;
`include "spd_consts.svh"

    typedef enum logic [1:0] {
        SPD_RT_BUS = 2'h0,
        SPD_RT_READ = 2'h1,
        SPD_RT_RESULT = 2'h2,
        SPD_RT_SHIFT = 2'h3
    } spd_route_e;

    typedef enum logic [2:0] {
        SPD_OP_CONST = 3'h0,
        SPD_OP_DIRECT = 3'h1,
        SPD_OP_EXTEND = 3'h2,
        SPD_OP_DUP_HI = 3'h3,
        SPD_OP_DUP_LO = 3'h4,
        SPD_OP_SWAP = 3'h5
    } spd_opsel_e;

    typedef enum logic [1:0] {
        SPD_CO_WORD = 2'h0,
        SPD_CO_BYTE = 2'h1,
        SPD_CO_MSB = 2'h2,
        SPD_CO_STATUS = 2'h3
    } spd_cout_e;

    typedef struct packed {
        logic [3:0] reg_addr;
        logic reg_write;
        spd_route_e route_sel;
        logic latch_load;
        spd_opsel_e opsel;
        logic [2:0] const_sel;
        logic logic_arith_select;
        logic [3:0] function_select;
        logic carry_base;
        logic carry_cond_en;
        spd_cout_e cout_sel;
        logic result_load;
        logic addr_load;
        logic status_load;
        logic cc_load;
        logic status_read;
    } spd_uword_s;

    typedef struct packed {
        logic zero_word;
        logic zero_hi;
        logic zero_lo;
        logic status_addr_hit;
        logic switch_addr_hit;
        logic stack_yellow;
        logic stack_red;
    } spd_flags_s;
endpackage

// ### verilog/spd_datapath.sv
/*
 * Sixteen-bit processor datapath: scratch bank, operand latch, constants,
 * result routing, ALU, result and address registers, decode, status word.
 * Assumes a single clock; software supplies the microword and fires each
 * machine state over Avalon-MM. Attached units share the read bus by OR.
 */
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "spd_consts.svh"

module spd_datapath
    import spd_pkg::*;
#(
    parameter logic [15:0] STATUS_ADDR = 16'hfffe,
    parameter logic [15:0] SWITCH_ADDR = 16'hff78,
    parameter logic [15:0] TRAP_VECTOR = 16'h0004,
    parameter logic [15:0] OFFSET_MASK = 16'h00ff
) (
    input wire logic clk, // Machine clock
    input wire logic resetn, // Async reset, active low
    input wire logic [5:0] avs_address, // Avalon byte address
    input wire logic avs_read, // Avalon read
    input wire logic avs_write, // Avalon write
    input wire logic [3:0] avs_byteenable, // Avalon byte lanes
    input wire logic [31:0] avs_writedata, // Avalon write data
    output logic [31:0] avs_readdata, // Avalon read data
    output logic avs_waitrequest, // Avalon wait
    input wire logic [15:0] sys_data_in, // Incoming system bus data
    input wire logic [15:0] ext_read_in, // Wired-OR read bus input
    input wire logic carry_cond_in, // Enabled carry condition
    input wire logic [3:0] cc_in, // Condition codes N Z V C
    input wire logic jumper_sel, // Jumper for conditional constant
    output logic [15:0] route_out, // Outgoing routed bus
    output logic [15:0] sys_data_out, // Data toward system bus
    output logic [15:0] bus_addr, // Bus address register
    output logic [7:0] status_word, // Status word
    output spd_pkg::spd_flags_s flags, // Decode flags
    output logic step_done // Pulse after a machine state
);
    import spd_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] second_fn(input spd_opsel_e sel,
                                              input logic [15:0] b,
                                              input logic [15:0] k);
        logic [15:0] r;
        r = k;
        case (sel)
            SPD_OP_CONST: r = k;
            SPD_OP_DIRECT: r = b; // RULE8
            SPD_OP_EXTEND: r = {{8{b[`SPD_SIGN_BIT]}}, b[7:0]}; // RULE9
            SPD_OP_DUP_HI: r = {b[15:8], b[15:8]}; // RULE10
            SPD_OP_DUP_LO: r = {b[7:0], b[7:0]}; // RULE10
            SPD_OP_SWAP: r = {b[7:0], b[15:8]}; // RULE11
            default: r = k;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    spd_uword_s uword;
    logic [15:0] yellow_limit;
    logic [15:0] red_limit;
    logic step;
    logic [15:0] d_reg;
    logic d_carry;
    logic [15:0] b_reg;
    logic [15:0] route_q;
    logic [31:0] next_rdata;
    logic wr_take;
    logic [31:0] uw32;
    logic [31:0] merged;

    // One wait state: request seen, then accepted on the next edge
    assign wr_take = avs_write && !avs_waitrequest;
    assign uw32 = {4'h0, uword};
    // Readback of the addressed register is the old value that lanes merge into
    assign merged = merge_be(next_rdata, avs_writedata, avs_byteenable);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_waitrequest && (avs_read || avs_write)) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (avs_address)
            `SPD_OFF_UWORD: next_rdata = uw32;
            `SPD_OFF_RESULT: next_rdata = {15'h0000, d_carry, d_reg};
            `SPD_OFF_ADDR: next_rdata = {16'h0000, bus_addr};
            `SPD_OFF_LATCH: next_rdata = {16'h0000, b_reg};
            `SPD_OFF_STATUS: next_rdata = {17'h00000, flags, status_word};
            `SPD_OFF_ROUTE: next_rdata = {16'h0000, route_q};
            `SPD_OFF_YLIM: next_rdata = {16'h0000, yellow_limit};
            `SPD_OFF_RLIM: next_rdata = {16'h0000, red_limit};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            uword <= spd_uword_s'(`SPD_UW_W'h0);
            yellow_limit <= `SPD_YLIM_RST;
            red_limit <= `SPD_RLIM_RST;
        end else if (wr_take) begin
            case (avs_address)
                `SPD_OFF_UWORD: uword <= spd_uword_s'(merged[`SPD_UW_W-1:0]);
                `SPD_OFF_YLIM: yellow_limit <= merged[15:0];
                `SPD_OFF_RLIM: red_limit <= merged[15:0];
                default: ;
            endcase
        end
    end

    // A machine state fires one cycle after the step write is accepted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step <= 1'b0;
        end else begin
            step <= wr_take && (avs_address == `SPD_OFF_STEP) && avs_byteenable[0]
                    && avs_writedata[`SPD_STEP_BIT]; // RULE24
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_done <= 1'b0;
        end else begin
            step_done <= step;
        end
    end

    // ----------------------------------------
    // Read bus and operands
    // ----------------------------------------
    logic [15:0] scratch [16];
    logic [15:0] scratch_rd;
    logic [15:0] status_rd;
    logic [15:0] read_bus;
    logic [15:0] route;
    logic [15:0] bconst;
    logic [15:0] second_operand;
    logic [15:0] first_operand;
    logic carry_in;

    // Single port: a write cycle never reads, so the bank drives zero
    assign scratch_rd = (!uword.reg_write && !uword.status_read) ?
                        scratch[uword.reg_addr] : `SPD_ZERO16; // RULE1 RULE26
    assign status_rd = uword.status_read ?
                       {`SPD_ZERO8, status_word} : `SPD_ZERO16; // RULE21 RULE26
    assign read_bus = scratch_rd | status_rd | ext_read_in; // RULE23
    assign first_operand = read_bus; // RULE2 RULE6

    always_comb begin
        route = sys_data_in;
        case (uword.route_sel) // RULE4
            SPD_RT_BUS: route = sys_data_in;
            SPD_RT_READ: route = read_bus;
            SPD_RT_RESULT: route = d_reg;
            SPD_RT_SHIFT: route = {d_carry, d_reg[15:1]};
            default: route = sys_data_in;
        endcase
    end

    always_comb begin
        bconst = `SPD_INC_ONE;
        case (uword.const_sel) // RULE7
            3'h0: bconst = `SPD_INC_ONE;
            3'h1: bconst = `SPD_INC_TWO;
            3'h2: bconst = SWITCH_ADDR;
            3'h3: bconst = TRAP_VECTOR;
            3'h4: bconst = OFFSET_MASK;
            3'h5: bconst = {15'h0000, status_word[`SPD_PS_C]};
            3'h6: bconst = jumper_sel ? `SPD_INC_TWO : `SPD_INC_ONE;
            default: bconst = `SPD_ZERO16;
        endcase
    end

    assign second_operand = second_fn(uword.opsel, b_reg, bconst); // RULE3
    // Carry-in is the raw microword bit, inverted by the condition input when enabled
    assign carry_in = uword.carry_base ^
                      (uword.carry_cond_en & carry_cond_in); // RULE14

    // ----------------------------------------
    // ALU
    // ----------------------------------------
    logic [15:0] p;
    logic [15:0] q;
    logic [15:0] alu_out;
    logic [16:0] sum;
    logic [8:0] lo_sum;
    logic word_carry;
    logic byte_carry;
    logic alu_msb;
    logic sel_carry;
    logic [15:0] a;
    logic [15:0] b;

    assign a = first_operand;
    assign b = second_operand;

    always_comb begin
        p = a;
        q = `SPD_ZERO16;
        case (uword.function_select) // RULE12
            4'h0: begin p = a; q = `SPD_ZERO16; end
            4'h1: begin p = a | b; q = `SPD_ZERO16; end
            4'h2: begin p = a | ~b; q = `SPD_ZERO16; end
            4'h3: begin p = `SPD_ONES16; q = `SPD_ZERO16; end
            4'h4: begin p = a; q = a & ~b; end
            4'h5: begin p = a | b; q = a & ~b; end
            4'h6: begin p = a; q = ~b; end
            4'h7: begin p = a & ~b; q = `SPD_ONES16; end
            4'h8: begin p = a; q = a & b; end
            4'h9: begin p = a; q = b; end
            4'ha: begin p = a | ~b; q = a & b; end
            4'hb: begin p = a & b; q = `SPD_ONES16; end
            4'hc: begin p = a; q = a; end
            4'hd: begin p = a | b; q = a; end
            4'he: begin p = a | ~b; q = a; end
            default: begin p = a; q = `SPD_ONES16; end
        endcase
    end

    assign sum = {1'b0, p} + {1'b0, q} + {16'h0000, carry_in};
    assign lo_sum = {1'b0, p[7:0]} + {1'b0, q[7:0]} + {8'h00, carry_in};

    always_comb begin
        alu_out = ~a;
        if (uword.logic_arith_select) begin
            case (uword.function_select)
                4'h0: alu_out = ~a;
                4'h1: alu_out = ~(a | b);
                4'h2: alu_out = ~a & b;
                4'h3: alu_out = `SPD_ZERO16;
                4'h4: alu_out = ~(a & b);
                4'h5: alu_out = ~b;
                4'h6: alu_out = a ^ b;
                4'h7: alu_out = a & ~b;
                4'h8: alu_out = ~a | b;
                4'h9: alu_out = ~(a ^ b);
                4'ha: alu_out = b;
                4'hb: alu_out = a & b;
                4'hc: alu_out = `SPD_ONES16;
                4'hd: alu_out = a | ~b;
                4'he: alu_out = a | b;
                default: alu_out = a;
            endcase
        end else begin
            alu_out = sum[15:0];
        end
    end

    // Logic mode produces no carries
    assign word_carry = !uword.logic_arith_select && sum[16];
    assign byte_carry = !uword.logic_arith_select && lo_sum[8];
    assign alu_msb = alu_out[`SPD_MSB];

    always_comb begin
        sel_carry = word_carry;
        case (uword.cout_sel) // RULE15
            SPD_CO_WORD: sel_carry = word_carry;
            SPD_CO_BYTE: sel_carry = byte_carry;
            SPD_CO_MSB: sel_carry = alu_msb;
            SPD_CO_STATUS: sel_carry = status_word[`SPD_PS_C];
            default: sel_carry = word_carry;
        endcase
    end

    // ----------------------------------------
    // Datapath registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                scratch[i] <= `SPD_ZERO16;
            end
        end else if (step && uword.reg_write) begin
            scratch[uword.reg_addr] <= route; // RULE22 RULE27
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            b_reg <= `SPD_ZERO16;
        end else if (step && uword.latch_load) begin
            b_reg <= route; // RULE5 RULE6
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            d_reg <= `SPD_ZERO16;
            d_carry <= 1'b0;
        end else if (step && uword.result_load) begin
            d_reg <= alu_out; // RULE13
            d_carry <= sel_carry; // RULE16
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_addr <= `SPD_ZERO16;
        end else if (step && uword.addr_load) begin
            bus_addr <= alu_out; // RULE13
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_word <= `SPD_ZERO8;
        end else if (step && uword.status_load) begin
            status_word <= route[7:0]; // RULE20 RULE25
        end else if (step && uword.cc_load) begin
            status_word[`SPD_PS_N:0] <= cc_in; // RULE20
        end
    end

    // ----------------------------------------
    // Decode and outgoing buses
    // ----------------------------------------
    // Decode looks at the held registers, so flags trail them by one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags <= '0;
        end else begin
            flags.zero_word <= (d_reg == `SPD_ZERO16); // RULE17
            flags.zero_hi <= (d_reg[15:8] == `SPD_ZERO8); // RULE17
            flags.zero_lo <= (d_reg[7:0] == `SPD_ZERO8); // RULE17
            flags.status_addr_hit <= (bus_addr == STATUS_ADDR); // RULE18
            flags.switch_addr_hit <= (bus_addr == SWITCH_ADDR); // RULE18
            flags.stack_yellow <= (bus_addr < yellow_limit)
                                  && !(bus_addr < red_limit); // RULE19
            flags.stack_red <= (bus_addr < red_limit); // RULE19
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            route_q <= `SPD_ZERO16;
            route_out <= `SPD_ZERO16;
        end else begin
            route_q <= route;
            route_out <= route; // RULE23
        end
    end

    // Switch values come from outside; only the status word is ours to gate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_data_out <= `SPD_ZERO16;
        end else if (bus_addr == STATUS_ADDR) begin
            sys_data_out <= {`SPD_ZERO8, status_word}; // RULE21
        end else begin
            sys_data_out <= d_reg;
        end
    end

endmodule

// ### dv/spd_far_model.sv
/* Far side: system bus data source and one attached read bus unit.
   Assumes the bench changes drive, attach and value after clock edges. */
`timescale 1ns/1ps
module spd_far_model (
    input wire logic clk, // Machine clock
    input wire logic drive, // Bus data driven
    input wire logic attach, // Attached unit selected
    input wire logic [15:0] value, // Value presented
    output logic [15:0] sys_data_in, // System bus data
    output logic [15:0] ext_read_in // Wired-OR read bus input
);
    logic [15:0] last = 16'h0000;
    // A released bus flips each cycle so stale data cannot pass
    always @(posedge clk) last <= drive ? value : ~last;
    assign sys_data_in = drive ? value : last;
    assign ext_read_in = attach ? value : 16'h0000;
endmodule

// ### dv/spd_datapath_assertions.sv
/* Checker on the datapath ports, bound in by the bench.
   Assumes one clock and the one-cycle lag of decode outputs. */
`timescale 1ns/1ps
module spd_datapath_assertions
    import spd_pkg::*;
#(
    parameter logic [15:0] STATUS_ADDR = 16'hfffe,
    parameter logic [15:0] SWITCH_ADDR = 16'hff78
) (
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic [5:0] avs_address, // Address
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic avs_waitrequest, // Wait
    input wire logic [15:0] sys_data_out, // Bus data out
    input wire logic [15:0] bus_addr, // Address register
    input wire logic [7:0] status_word, // Status word
    input wire spd_pkg::spd_flags_s flags, // Decode flags
    input wire logic step_done // Step pulse
);
    logic [1:0] up;
    // Decode lags the registers, so the first edges after reset are skipped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    wire up_ok = (up == 2'h3);
    wire go = avs_write && !avs_waitrequest && avs_address == 6'h04 && avs_writedata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_step_cause:
    assert property (step_done |-> $past(go, 2)) else $error("step without step write");
    chk_step_pulse:
    assert property (step_done |=> !step_done) else $error("step pulse too long");
    chk_hold_regs:
    assert property ($changed(bus_addr) || $changed(status_word) |-> step_done)
        else $error("register changed without step");
    chk_zero_word:
    assert property (up_ok && $stable(bus_addr) && bus_addr != STATUS_ADDR
        |-> flags.zero_word == (sys_data_out == 16'h0000)) else $error("word zero flag wrong");
    chk_zero_bytes:
    assert property (up_ok && $stable(bus_addr) && bus_addr != STATUS_ADDR
        |-> flags.zero_hi == (sys_data_out[15:8] == 8'h00) && flags.zero_lo ==
        (sys_data_out[7:0] == 8'h00)) else $error("byte zero flag wrong");
    chk_status_hit:
    assert property (up_ok && $stable(bus_addr)
        |-> flags.status_addr_hit == (bus_addr == STATUS_ADDR)) else $error("status hit wrong");
    chk_switch_hit:
    assert property (up_ok && $stable(bus_addr)
        |-> flags.switch_addr_hit == (bus_addr == SWITCH_ADDR)) else $error("switch hit wrong");
    chk_status_out:
    assert property (up_ok && $stable(bus_addr) && $stable(status_word) && bus_addr ==
        STATUS_ADDR |-> sys_data_out == {8'h00, status_word}) else $error("status not on bus");
    chk_stack_zone:
    assert property (!(flags.stack_yellow && flags.stack_red)) else $error("both stack zones");
    cover property (step_done);
    cover property (flags.stack_yellow);
    cover property (up_ok && flags.status_addr_hit);
endmodule

// ### dv/testbench.sv
/* Self-checking bench: Avalon tasks and microword step sequences.
   Assumes the far-side model and the checker are compiled first. */
`timescale 1ns/1ps
bind spd_datapath spd_datapath_assertions #(.STATUS_ADDR(STATUS_ADDR),
    .SWITCH_ADDR(SWITCH_ADDR)) u_chk (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .sys_data_out(sys_data_out), .bus_addr(bus_addr), .status_word(status_word),
    .flags(flags), .step_done(step_done));
module testbench;
    import spd_pkg::*;
    localparam logic [15:0] SW = 16'hff78, TV = 16'h0004, OM = 16'h00ff;
    logic clk = 1'b0, resetn = 1'b0, rd = 1'b0, wr = 1'b0, drive = 1'b0, attach = 1'b0;
    logic cond = 1'b0, jmp = 1'b1, wreq, step_done;
    logic [3:0] cc = 4'h0;
    logic [5:0] addr = 6'h00;
    logic [15:0] value = 16'h0000, sys_in, ext_in, sys_data_out, bus_addr, route_o;
    logic [7:0] status_word;
    logic [31:0] wdata = 32'h0, rdata, got;
    spd_flags_s flags;
    int error_cnt = 0, n_tests = 0;
    logic [15:0] exp_b [1:13] = '{16'h3496, 16'hff96, 16'h3434, 16'h9696, 16'h9634,
        16'h0001, 16'h0002, SW, TV, OM, 16'h0000, 16'h0002, 16'h0000};
    initial forever #25 clk = ~clk;
    spd_far_model far (.clk(clk), .drive(drive), .attach(attach), .value(value),
        .sys_data_in(sys_in), .ext_read_in(ext_in));
    spd_datapath #(.SWITCH_ADDR(SW), .TRAP_VECTOR(TV), .OFFSET_MASK(OM)) dut (.clk(clk),
        .resetn(resetn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_byteenable(4'hf), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .sys_data_in(sys_in), .ext_read_in(ext_in),
        .carry_cond_in(cond), .cc_in(cc), .jumper_sel(jmp), .route_out(route_o),
        .sys_data_out(sys_data_out), .bus_addr(bus_addr), .status_word(status_word),
        .flags(flags), .step_done(step_done));
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("[FAIL] %0t wait ran out", $time);
        results();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 20) tmo();
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(got, e);
    endtask
    task automatic step(input logic [27:0] u);
        int n;
        n = 0;
        bus(1'b1, 6'h00, {4'h0, u});
        bus(1'b1, 6'h04, 32'h1);
        while (step_done !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        if (n == 10) tmo();
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rdchk(6'h1c, 32'h100);
        rdchk(6'h20, 32'he0);
        rdchk(6'h14, 32'h7100);
        bus(1'b1, 6'h08, 32'hffff);
        rdchk(6'h08, 32'h0);
        rdchk(6'h3c, 32'h0);
        $display("reset test done");
        drive <= 1'b1;
        value <= 16'h12f0;
        step(28'h3800000);
        value <= 16'hf381;
        step(28'h5800000);
        drive <= 1'b0;
        step(28'h3300000);
        rdchk(6'h10, 32'h12f0);
        step(28'h5021210);
        rdchk(6'h08, 32'h10671);
        cond <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            step(28'h5021290 | (28'(c) << 5));
            rdchk(6'h08, {15'h0, c < 2, 16'h0672});
        end
        step(28'h5021390);
        rdchk(6'h08, 32'h10671);
        step(28'h0700000);
        rdchk(6'h10, 32'h8338);
        $display("carry test done");
        drive <= 1'b1;
        value <= 16'h3496;
        step(28'h0100000);
        jmp <= 1'b0;
        step(28'h001b410);
        rdchk(6'h08, 32'h1);
        jmp <= 1'b1;
        for (int i = 1; i < 14; i++) begin
            step(28'h0003410 | (28'((i < 6) ? i : 0) << 17) | (28'((i - 6) & 7) << 14));
            rdchk(6'h08, {16'h0, exp_b[i]});
        end
        $display("operand test done");
        value <= 16'h00a5;
        step(28'h0000004);
        chk({24'h0, status_word}, 32'ha5);
        cc <= 4'ha;
        step(28'h0000002);
        chk({24'h0, status_word}, 32'haa);
        value <= 16'h0033;
        step(28'h0000006);
        chk({24'h0, status_word}, 32'h33);
        drive <= 1'b0;
        step(28'h0300001);
        rdchk(6'h10, 32'h33);
        attach <= 1'b1;
        value <= 16'h0a00;
        step(28'h0300001);
        rdchk(6'h10, 32'h0a33);
        chk({16'h0, route_o}, 32'h0a33);
        attach <= 1'b0;
        $display("status test done");
        step(28'h0013408);
        rdchk(6'h14, 32'h7233);
        step(28'h000b408);
        rdchk(6'h14, 32'h7433);
        rdchk(6'h0c, 32'hff78);
        drive <= 1'b1;
        value <= 16'hfffe;
        step(28'h9800000);
        drive <= 1'b0;
        step(28'h9003e08);
        rdchk(6'h14, 32'h7833);
        chk({16'h0, sys_data_out}, 32'h33);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdchk(6'h14, 32'h7100);
        $display("decode test done");
        results();
    end
endmodule
